// [eal_pkg.sv]
// Constants, types and helpers shared by the serial memory access controller.
// Summary of operation
// - The start bit drops back to zero by itself once the requested memory access is finished.
// - Writing the start bit from zero to one while no autoload runs launches one access, read when the command bit is 0, write when it is 1.
// - The read-only error bit 2 is set when the memory misses an acknowledge and reads zero otherwise.
// - Read-only bit 3 reads one only after an autoload finished without error, zero from reset on.
// - The serial clock is the core clock divided by 4096, 2048, 1024 or 128 for select 00, 01, 10, 11, reset 00.
// - Autoload starts after reset with bit 6 at zero, its reset value; writing it to one stops autoload after the word in progress.
// - With the fast bit at one, its reset value, autoload runs eight times faster than normal.
// - Read-only bit 8 is one for the whole time an autoload runs and zero otherwise.
// - The 7-bit field in bits 15:9, reset zero, gives the memory word used by each software access.
// - The 16-bit field in bits 31:16, reset zero, is the word stored by a write access.
package eal_pkg;

	// Register location and field positions
	localparam logic [7:0] EAL_REG_OFFSET = 8'h70;
	localparam int EAL_START_BIT = 0;
	localparam int EAL_CMD_BIT = 1;
	localparam int EAL_ERR_BIT = 2;
	localparam int EAL_ALOK_BIT = 3;
	localparam int EAL_DIV_LSB = 4;
	localparam int EAL_ALDIS_BIT = 6;
	localparam int EAL_FAST_BIT = 7;
	localparam int EAL_ALBUSY_BIT = 8;
	localparam int EAL_ADDR_LSB = 9;
	localparam int EAL_DATA_LSB = 16;

	// Values after reset
	localparam logic [1:0] EAL_DIV_RST = 2'h0;
	localparam logic EAL_ALDIS_RST = 1'h0;
	localparam logic EAL_FAST_RST = 1'h1;
	localparam logic [6:0] EAL_ADDR_RST = 7'h00;
	localparam logic [15:0] EAL_DATA_RST = 16'h0000;

	// Serial clock divisors in core clock cycles per serial bit
	localparam logic [12:0] EAL_DIV_4096 = 13'h1000;
	localparam logic [12:0] EAL_DIV_2048 = 13'h0800;
	localparam logic [12:0] EAL_DIV_1024 = 13'h0400;
	localparam logic [12:0] EAL_DIV_128 = 13'h0080;
	localparam int EAL_PHASE_SHIFT = 2; // Four phases per serial bit
	localparam int EAL_FAST_SHIFT = 3; // Fast autoload divides by eight

	// Sequence steps of one access
	localparam logic [2:0] EAL_RD_LAST = 3'h7;
	localparam logic [2:0] EAL_WR_LAST = 3'h5;

	typedef enum logic [1:0] {EAL_OP_START, EAL_OP_STOP, EAL_OP_WRITE, EAL_OP_READ} eal_op_t;
	typedef enum logic [1:0] {EAL_IDLE, EAL_ISSUE, EAL_WAIT} eal_seq_t;

	typedef struct packed {
		eal_op_t op;
		logic [7:0] data;
		logic ack_n;
	} eal_cmd_t;

	typedef struct packed {
		logic done;
		logic nack;
		logic [7:0] rbyte;
	} eal_rsp_t;

	typedef struct packed {
		logic start;
		logic cmd;
		logic [1:0] div_sel;
		logic al_dis;
		logic fast;
		logic [6:0] word_addr;
		logic [15:0] data;
	} eal_cfg_t;

	typedef struct packed {
		logic valid;
		logic [6:0] addr;
		logic [15:0] data;
	} eal_load_t;

	// Core cycles per quarter serial bit
	function automatic logic [12:0] eal_quarter_period(input logic [1:0] sel, input logic fast);
		logic [12:0] base;
		base = EAL_DIV_4096;
		unique case (sel)
			2'h0: base = EAL_DIV_4096;
			2'h1: base = EAL_DIV_2048;
			2'h2: base = EAL_DIV_1024;
			2'h3: base = EAL_DIV_128;
		endcase
		base = base >> EAL_PHASE_SHIFT;
		if (fast) begin
			base = base >> EAL_FAST_SHIFT;
		end
		return base;
	endfunction : eal_quarter_period

endpackage : eal_pkg

// [eal_clk_div.sv]
// Quarter-bit tick divider for the serial clock.
module eal_clk_div import eal_pkg::*; #(
	parameter int CNT_W = 13
) (
	input wire logic clk, // Core clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic run, // Count while high
	input wire logic [1:0] sel, // Divisor select
	input wire logic fast, // Eight times faster
	output logic tick // One-cycle quarter-bit pulse
);

	// Elaboration check on the counter width
	if (CNT_W < 13) begin : gen_cnt_w_chk
		$error("eal_clk_div: CNT_W too small for the largest divisor");
	end

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} eal_div_st_t;

	eal_div_st_t s_q, s_d;
	logic [CNT_W-1:0] lim;

	// Counter wraps at the selected quarter period
	always_comb begin
		lim = CNT_W'(eal_quarter_period(sel, fast));
		s_d = s_q;
		tick = 1'b0;
		if (!run) begin
			s_d.cnt = '0;
		end else if (s_q.cnt >= lim - CNT_W'(1)) begin // Wraps at once if the rate rose
			s_d.cnt = '0;
			tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	div_first_tick_a: assert property (@(posedge clk) disable iff (reset)
		(run && !$past(run) && sel == 2'h3 && !fast) |-> !tick [*8])
		else $error("first tick too soon after run");
	div_normal_gap_a: assert property (@(posedge clk) disable iff (reset)
		(tick && run && sel == 2'h3 && !fast && $stable(sel) && $stable(fast))
		|=> !tick [*8])
		else $error("divide by 128 ticks too close");

endmodule : eal_clk_div

// [eal_serial_engine.sv]
// Two-wire bit engine: start, stop, byte write with acknowledge check, byte read.
module eal_serial_engine import eal_pkg::*; (
	input wire logic clk, // Core clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic tick, // Quarter-bit enable
	input wire logic cmd_valid, // Command offered
	input wire eal_cmd_t cmd, // Operation, byte, ack level
	output logic busy, // Command in progress
	output eal_rsp_t rsp, // Done pulse, nack, read byte
	output logic scl, // Serial clock
	input wire logic sda_in, // Data line level
	output logic sda_out, // Data driven value
	output logic sda_oe // Data drive enable
);

	typedef struct packed {
		logic active;
		eal_op_t op;
		logic [1:0] phase;
		logic [3:0] bitn;
		logic [7:0] shift;
		logic ackbit;
		logic rel;
		logic scl;
		logic nack;
		logic done;
	} eal_eng_t;

	eal_eng_t s_q, s_d;

	// Phase sequencer, one step per tick
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (!s_q.active) begin
			if (cmd_valid) begin
				s_d.active = 1'b1;
				s_d.op = cmd.op;
				s_d.phase = 2'h0;
				s_d.bitn = 4'h0;
				s_d.shift = cmd.data;
				s_d.ackbit = cmd.ack_n;
				s_d.nack = 1'b0;
			end
		end else if (tick) begin
			s_d.phase = s_q.phase + 2'h1;
			unique case (s_q.op)
				EAL_OP_START: begin
					unique case (s_q.phase)
						2'h0: begin s_d.rel = 1'b1; s_d.scl = 1'b0; end
						2'h1: s_d.scl = 1'b1;
						2'h2: s_d.rel = 1'b0;
						2'h3: begin s_d.scl = 1'b0; s_d.active = 1'b0; s_d.done = 1'b1; end
					endcase
				end
				EAL_OP_STOP: begin
					unique case (s_q.phase)
						2'h0: begin s_d.rel = 1'b0; s_d.scl = 1'b0; end
						2'h1: s_d.scl = 1'b1;
						2'h2: s_d.rel = 1'b1;
						2'h3: begin s_d.active = 1'b0; s_d.done = 1'b1; end
					endcase
				end
				EAL_OP_WRITE, EAL_OP_READ: begin
					unique case (s_q.phase)
						2'h0: begin
							s_d.scl = 1'b0;
							if (s_q.bitn < 4'h8) begin
								s_d.rel = (s_q.op == EAL_OP_WRITE) ? s_q.shift[7] : 1'b1;
							end else begin
								s_d.rel = (s_q.op == EAL_OP_WRITE) ? 1'b1 : s_q.ackbit;
							end
						end
						2'h1: s_d.scl = 1'b1;
						2'h2: begin
							if (s_q.bitn < 4'h8) begin
								s_d.shift = (s_q.op == EAL_OP_READ) ?
									{s_q.shift[6:0], sda_in} : {s_q.shift[6:0], 1'b0};
							end else if (s_q.op == EAL_OP_WRITE) begin
								s_d.nack = sda_in;
							end
						end
						2'h3: begin
							s_d.scl = 1'b0;
							if (s_q.bitn == 4'h8) begin
								s_d.active = 1'b0;
								s_d.done = 1'b1;
							end else begin
								s_d.bitn = s_q.bitn + 4'h1;
							end
						end
					endcase
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '{active: 1'b0, op: EAL_OP_START, phase: 2'h0, bitn: 4'h0, shift: 8'h00,
				ackbit: 1'b1, rel: 1'b1, scl: 1'b1, nack: 1'b0, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs; data line is open drain, low only
	assign busy = s_q.active;
	assign rsp = '{done: s_q.done, nack: s_q.nack, rbyte: s_q.shift};
	assign scl = s_q.scl;
	assign sda_out = 1'b0;
	assign sda_oe = ~s_q.rel;

endmodule : eal_serial_engine

// [eal_access_ctrl.sv]
// Serial memory access and autoload controller with its control/status register.
module eal_access_ctrl import eal_pkg::*; #(
	parameter int AL_WORDS = 64,
	parameter logic [7:0] DEV_SEL = 8'hA0
) (
	input wire logic clk, // Core clock
	input wire logic reset, // Asynchronous reset, active high
	input wire logic [7:0] cfg_addr, // Configuration byte address
	input wire logic cfg_wr, // Configuration write strobe
	input wire logic cfg_rd, // Configuration read strobe
	input wire logic [3:0] cfg_be, // Write byte enables
	input wire logic [31:0] cfg_wdata, // Write data
	output logic [31:0] cfg_rdata, // Read data, one cycle after cfg_rd
	output eal_load_t al_load, // Autoloaded word strobe
	output logic ee_scl, // Serial clock
	input wire logic ee_sda_in, // Data line level
	output logic ee_sda_out, // Data driven value
	output logic ee_sda_oe // Data drive enable
);

	// Elaboration checks on the parameters
	if (AL_WORDS < 1 || AL_WORDS > 128) begin : gen_words_chk
		$error("eal_access_ctrl: AL_WORDS must be 1 to 128");
	end
	if (DEV_SEL[0] != 1'b0) begin : gen_sel_chk
		$error("eal_access_ctrl: DEV_SEL must be a write selector");
	end

	typedef struct packed {
		eal_cfg_t cfg;
		logic err;
		logic al_ok;
		logic al_busy;
		logic al_pending;
		logic sw_busy;
		logic wr;
		eal_seq_t st;
		logic [2:0] step;
		logic [6:0] word_addr;
		logic [15:0] rdword;
		eal_load_t load;
		logic [31:0] rdata;
	} eal_ctrl_t;

	eal_ctrl_t s_q, s_d;
	eal_cmd_t eng_cmd;
	eal_rsp_t eng_rsp;
	logic eng_busy;
	logic eng_valid;
	logic div_tick;
	logic hit_wr;
	logic launch;
	logic last_step;

	// Command byte for one step of a word access
	function automatic eal_cmd_t seq_cmd(input logic wr, input logic [2:0] step,
		input logic [6:0] addr, input logic [15:0] data);
		eal_cmd_t c;
		c = '{op: EAL_OP_WRITE, data: DEV_SEL, ack_n: 1'b1};
		if (wr) begin
			unique case (step)
				3'h0: c.op = EAL_OP_START;
				3'h1: c.data = DEV_SEL;
				3'h2: c.data = {addr, 1'b0};
				3'h3: c.data = data[15:8];
				3'h4: c.data = data[7:0];
				default: c.op = EAL_OP_STOP;
			endcase
		end else begin
			unique case (step)
				3'h0: c.op = EAL_OP_START;
				3'h1: c.data = DEV_SEL;
				3'h2: c.data = {addr, 1'b0};
				3'h3: c.op = EAL_OP_START;
				3'h4: c.data = DEV_SEL | 8'h01;
				3'h5: begin c.op = EAL_OP_READ; c.ack_n = 1'b0; end
				3'h6: begin c.op = EAL_OP_READ; c.ack_n = 1'b1; end
				3'h7: c.op = EAL_OP_STOP;
			endcase
		end
		return c;
	endfunction : seq_cmd

	// Decode of the register strobes
	always_comb begin
		hit_wr = cfg_wr && (cfg_addr == EAL_REG_OFFSET);
		launch = hit_wr && cfg_be[0] && cfg_wdata[EAL_START_BIT] && !s_q.cfg.start
			&& (s_q.st == EAL_IDLE) && !s_q.al_pending;
		last_step = (s_q.step == (s_q.wr ? EAL_WR_LAST : EAL_RD_LAST));
		eng_cmd = seq_cmd(s_q.wr, s_q.step, s_q.word_addr, s_q.cfg.data);
		eng_valid = (s_q.st == EAL_ISSUE) && !eng_busy;
	end

	// Register writes, access sequencing and autoload
	always_comb begin
		s_d = s_q;
		s_d.load.valid = 1'b0;
		if (hit_wr && cfg_be[0]) begin
			s_d.cfg.cmd = cfg_wdata[EAL_CMD_BIT];
			s_d.cfg.div_sel = cfg_wdata[EAL_DIV_LSB +: 2];
			s_d.cfg.al_dis = cfg_wdata[EAL_ALDIS_BIT];
			s_d.cfg.fast = cfg_wdata[EAL_FAST_BIT];
		end
		if (hit_wr && cfg_be[1]) begin
			s_d.cfg.word_addr = cfg_wdata[EAL_ADDR_LSB +: 7];
		end
		if (hit_wr && cfg_be[2]) begin
			s_d.cfg.data[7:0] = cfg_wdata[EAL_DATA_LSB +: 8];
		end
		if (hit_wr && cfg_be[3]) begin
			s_d.cfg.data[15:8] = cfg_wdata[EAL_DATA_LSB + 8 +: 8];
		end
		if (cfg_rd) begin
			s_d.rdata = '0;
			if (cfg_addr == EAL_REG_OFFSET) begin
				s_d.rdata = {s_q.cfg.data, s_q.cfg.word_addr, s_q.al_busy, s_q.cfg.fast,
					s_q.cfg.al_dis, s_q.cfg.div_sel, s_q.al_ok, s_q.err,
					s_q.cfg.cmd, s_q.cfg.start};
			end
		end
		unique case (s_q.st)
			EAL_IDLE: begin
				if (s_q.al_pending) begin
					s_d.al_pending = 1'b0;
					if (!s_q.cfg.al_dis) begin
						s_d.al_busy = 1'b1;
						s_d.err = 1'b0;
						s_d.wr = 1'b0;
						s_d.word_addr = 7'h00;
						s_d.step = 3'h0;
						s_d.st = EAL_ISSUE;
					end
				end else if (launch) begin
					s_d.cfg.start = 1'b1;
					s_d.sw_busy = 1'b1;
					s_d.err = 1'b0;
					s_d.wr = s_d.cfg.cmd;
					s_d.word_addr = s_d.cfg.word_addr;
					s_d.step = 3'h0;
					s_d.st = EAL_ISSUE;
				end
			end
			EAL_ISSUE: begin
				if (!eng_busy) begin
					s_d.st = EAL_WAIT;
				end
			end
			EAL_WAIT: begin
				if (eng_rsp.done) begin
					if (eng_rsp.nack) begin
						s_d.err = 1'b1;
					end
					if (!s_q.wr && s_q.step == 3'h5) begin
						s_d.rdword[15:8] = eng_rsp.rbyte;
					end
					if (!s_q.wr && s_q.step == 3'h6) begin
						s_d.rdword[7:0] = eng_rsp.rbyte;
					end
					if (!last_step) begin
						s_d.step = s_q.step + 3'h1;
						s_d.st = EAL_ISSUE;
					end else if (s_q.sw_busy) begin
						s_d.cfg.start = 1'b0;
						s_d.sw_busy = 1'b0;
						if (!s_q.wr) begin
							s_d.cfg.data = s_q.rdword;
						end
						s_d.st = EAL_IDLE;
					end else begin
						s_d.load = '{valid: 1'b1, addr: s_q.word_addr, data: s_q.rdword};
						if (s_q.word_addr == 7'(AL_WORDS - 1) || s_q.cfg.al_dis) begin
							s_d.al_busy = 1'b0;
							s_d.al_ok = !s_d.err && !s_q.cfg.al_dis;
							s_d.st = EAL_IDLE;
						end else begin
							s_d.word_addr = s_q.word_addr + 7'h01;
							s_d.step = 3'h0;
							s_d.st = EAL_ISSUE;
						end
					end
				end
			end
			default: s_d.st = EAL_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '{cfg: '{start: 1'b0, cmd: 1'b0, div_sel: EAL_DIV_RST, al_dis: EAL_ALDIS_RST,
				fast: EAL_FAST_RST, word_addr: EAL_ADDR_RST, data: EAL_DATA_RST},
				err: 1'b0, al_ok: 1'b0, al_busy: 1'b0, al_pending: 1'b1, sw_busy: 1'b0,
				wr: 1'b0, st: EAL_IDLE, step: 3'h0, word_addr: 7'h00, rdword: 16'h0000,
				load: '0, rdata: 32'h00000000};
		end else begin
			s_q <= s_d;
		end
	end

	// Serial clock rate; fast mode only while autoloading
	eal_clk_div eal_clk_div_inst (
		.clk(clk),
		.reset(reset),
		.run(s_q.st != EAL_IDLE),
		.sel(s_q.cfg.div_sel),
		.fast(s_q.cfg.fast && s_q.al_busy),
		.tick(div_tick)
	);

	eal_serial_engine eal_serial_engine_inst (
		.clk(clk),
		.reset(reset),
		.tick(div_tick),
		.cmd_valid(eng_valid),
		.cmd(eng_cmd),
		.busy(eng_busy),
		.rsp(eng_rsp),
		.scl(ee_scl),
		.sda_in(ee_sda_in),
		.sda_out(ee_sda_out),
		.sda_oe(ee_sda_oe)
	);

	assign cfg_rdata = s_q.rdata;
	assign al_load = s_q.load;

	start_clear_a: assert property (@(posedge clk) disable iff (reset)
		(s_q.sw_busy && s_q.st == EAL_WAIT && eng_rsp.done && last_step)
		|=> !s_q.cfg.start && s_q.st == EAL_IDLE)
		else $error("start bit not cleared at access end");
	launch_busy_a: assert property (@(posedge clk) disable iff (reset)
		launch |=> s_q.sw_busy && s_q.cfg.start && s_q.wr == $past(cfg_wdata[EAL_CMD_BIT])
		&& s_q.st == EAL_ISSUE)
		else $error("launch did not start the requested access");
	nack_err_a: assert property (@(posedge clk) disable iff (reset)
		(s_q.st == EAL_WAIT && eng_rsp.done && eng_rsp.nack) |=> s_q.err)
		else $error("missed acknowledge not flagged");
	al_ok_a: assert property (@(posedge clk) disable iff (reset)
		$rose(s_q.al_ok) |-> $past(s_q.al_busy) && !s_q.al_busy && !s_q.err)
		else $error("autoload complete without a clean autoload");
	al_skip_a: assert property (@(posedge clk) disable iff (reset)
		(s_q.load.valid && $past(s_q.cfg.al_dis)) |-> !s_q.al_busy && !s_q.al_ok)
		else $error("autoload went on while disabled");
	fast_rate_a: assert property (@(posedge clk) disable iff (reset)
		(div_tick && s_q.al_busy && s_q.cfg.fast && s_q.cfg.div_sel == 2'h3)
		##1 (s_q.al_busy && s_q.cfg.fast && s_q.cfg.div_sel == 2'h3 && s_q.st != EAL_IDLE) [*4]
		|-> div_tick && !$past(div_tick) && !$past(div_tick, 2) && !$past(div_tick, 3))
		else $error("fast autoload tick spacing wrong");
	al_status_a: assert property (@(posedge clk) disable iff (reset)
		(cfg_rd && cfg_addr == EAL_REG_OFFSET) |=> cfg_rdata[EAL_ALBUSY_BIT] == $past(s_q.al_busy))
		else $error("autoload status bit does not follow autoload");
	word_addr_a: assert property (@(posedge clk) disable iff (reset)
		(eng_valid && s_q.sw_busy && s_q.step == 3'h2) |-> eng_cmd.data == {s_q.cfg.word_addr, 1'b0})
		else $error("wrong word address sent");
	wr_data_a: assert property (@(posedge clk) disable iff (reset)
		(eng_valid && s_q.wr && s_q.step == 3'h3) |-> eng_cmd.data == s_q.cfg.data[15:8]
		&& eng_cmd.op == EAL_OP_WRITE)
		else $error("wrong write data sent");
	rd_back_a: assert property (@(posedge clk) disable iff (reset)
		(s_q.sw_busy && !s_q.wr && s_q.st == EAL_WAIT && eng_rsp.done && last_step)
		|=> s_q.cfg.data == $past(s_q.rdword))
		else $error("read word not placed in data field");

endmodule : eal_access_ctrl

// [eal_ee_model.sv]
// Behavioural two-wire serial memory that answers the access controller.
module eal_ee_model #(
	parameter logic [7:0] DEV_SEL = 8'hA0
) (
	input wire logic scl, // Serial clock from the master
	input wire logic sda, // Resolved data line level
	input wire logic nack_en, // Withhold every acknowledge
	output logic pull_low = 1'h0 // Pull the data line low
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256];
	logic [7:0] sh = 8'h00;
	logic [7:0] tx = 8'h00;
	logic [7:0] ptr = 8'h00;
	logic act = 1'h0;
	logic skip = 1'h0;
	logic sel = 1'h0;
	logic rd = 1'h0;
	logic snd = 1'h0;
	logic mack = 1'h0;
	int bitn = 0;
	int nb = 0;

	// Preset contents, same pattern as the bench's shadow copy
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'(i * 37 + 11);
		end
	end

	// Start condition restarts the byte framing
	always @(negedge sda) begin
		if (scl === 1'h1) begin
			act = 1'h1;
			skip = 1'h1;
			snd = 1'h0;
			bitn = 0;
			nb = 0;
			pull_low = 1'h0;
		end
	end

	// Stop condition ends the transfer
	always @(posedge sda) begin
		if (scl === 1'h1) begin
			act = 1'h0;
		end
	end

	// Sample data bits and the master's acknowledge
	always @(posedge scl) begin
		if (act && bitn < 8) begin
			sh = {sh[6:0], sda};
		end else begin
			mack = !sda;
		end
	end

	// Drive acknowledge and read bits while the clock is low
	always @(negedge scl) begin
		if (act && skip) begin
			skip = 1'h0;
		end else if (act && bitn == 7) begin
			bitn = 8;
			if (!snd) begin
				if (nb == 0) begin
					sel = (sh[7:1] == DEV_SEL[7:1]) && !nack_en;
					rd = sh[0];
				end else if (sel && nb == 1) begin
					ptr = sh;
				end else if (sel && !rd) begin
					mem[ptr] = sh;
					ptr = ptr + 8'h01;
				end
			end
			pull_low = sel && !snd; // Acknowledge unless withheld
		end else if (act && bitn == 8) begin
			bitn = 0;
			nb = nb + 1;
			snd = sel && rd && (nb == 1 || mack);
			tx = mem[ptr];
			if (snd) begin
				ptr = ptr + 8'h01;
			end
			pull_low = snd && !tx[7];
		end else if (act) begin
			bitn = bitn + 1;
			tx = tx << 1;
			pull_low = snd && !tx[7];
		end
	end
endmodule : eal_ee_model

// [tb_top.sv]
// Self-checking bench for the serial memory access and autoload controller.
module tb_top import eal_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, reset, cfg_wr, cfg_rd, ee_scl, ee_sda_out, ee_sda_oe, pull_low, nack_en, sda;
	logic [7:0] cfg_addr;
	logic [3:0] cfg_be;
	logic [31:0] cfg_wdata, cfg_rdata, v, keep;
	eal_load_t al_load;
	logic [7:0] shadow [256];
	logic [23:0] rnd;
	int err_count, samples_checked, al_idx, seed, n;

	// Open-drain data line with pull-up
	assign sda = ((ee_sda_oe && !ee_sda_out) || pull_low) ? 1'h0 : 1'h1;

	eal_access_ctrl #(.AL_WORDS(2), .DEV_SEL(8'hA0)) eal_access_ctrl_inst (.clk(clk),
		.reset(reset), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
		.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .al_load(al_load), .ee_scl(ee_scl),
		.ee_sda_in(sda), .ee_sda_out(ee_sda_out), .ee_sda_oe(ee_sda_oe));
	eal_ee_model #(.DEV_SEL(8'hA0)) eal_ee_model_inst (.scl(ee_scl), .sda(sda),
		.nack_en(nack_en), .pull_low(pull_low));

	// 200 MHz clock
	always #2.5 clk = ~clk;

	function automatic int hi_len(input int s);
		int d [4] = '{4096, 2048, 1024, 128};
		return d[s] / 16;
	endfunction : hi_len

	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : check

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
		cfg_rd = 1'h0;
		cfg_addr = a;
		cfg_wdata = d;
		cfg_be = be;
		cfg_wr = 1'h1;
		@(posedge clk);
		#1;
		cfg_wr = 1'h0;
	endtask : reg_wr

	// Read strobe stays up between reads, so it is never set twice in one step
	task automatic reg_rd(input logic [7:0] a);
		cfg_addr = a;
		cfg_rd = 1'h1;
		@(posedge clk);
		#1;
		v = cfg_rdata;
	endtask : reg_rd

	// Poll the register until the masked bits read zero
	task automatic poll_clear(input logic [31:0] m);
		int g;
		g = 0;
		reg_rd(8'h70);
		while ((v & m) !== 32'h0 && g < 40000) begin
			reg_rd(8'h70);
			g++;
		end
	endtask : poll_clear

	// Cycles of one full serial clock high pulse
	task automatic measure;
		int g;
		n = 0;
		g = 0;
		while (ee_scl !== 1'h0 && g < 30000) begin
			@(posedge clk);
			#1;
			g++;
		end
		while (ee_scl !== 1'h1 && g < 30000) begin
			@(posedge clk);
			#1;
			g++;
		end
		while (ee_scl === 1'h1 && g < 30000) begin
			@(posedge clk);
			#1;
			g++;
			n++;
		end
	endtask : measure

	task automatic do_reset;
		reset = 1'h1;
		repeat (4) @(posedge clk);
		#1;
		reset = 1'h0;
		al_idx = 0;
		@(posedge clk);
		#1;
		reg_rd(8'h70);
		check("reset value", 32'h0000_0180, v);
	endtask : do_reset

	// One software access; read-only bits are written as ones on purpose
	task automatic do_access(input logic c, input logic [6:0] a, input logic [15:0] d,
		input logic nk);
		logic [15:0] e;
		nack_en = nk;
		reg_wr(8'h70, {d, a, 1'h1, 4'hB, 2'h3, c, 1'h1}, 4'hF);
		poll_clear(32'h1);
		e = c ? d : (nk ? 16'hFFFF : {shadow[{a, 1'h0}], shadow[{a, 1'h1}]});
		if (c && !nk) begin
			shadow[{a, 1'h0}] = d[15:8];
			shadow[{a, 1'h1}] = d[7:0];
		end
		check("access reg", {e, a, 1'h0, 4'hB, 1'h1, nk, c, 1'h0}, v);
		check("stored word", {16'h0, shadow[{a, 1'h0}], shadow[{a, 1'h1}]},
			{16'h0, eal_ee_model_inst.mem[{a, 1'h0}], eal_ee_model_inst.mem[{a, 1'h1}]});
		$display("test access cmd %0d word %h done", c, a);
	endtask : do_access

	// Autoloaded words against the shadow copy, sampled mid-cycle
	always @(negedge clk) begin
		if (!reset && al_load.valid === 1'h1) begin
			check("load addr", 32'(al_idx), {25'h0, al_load.addr});
			check("load data", {16'h0, shadow[8'(2 * al_idx)], shadow[8'(2 * al_idx + 1)]},
				{16'h0, al_load.data});
			al_idx++;
		end
	end

	// Watchdog against a hung sequence
	initial begin
		#(90000 * 5);
		err_count++;
		conclude();
	end

	initial begin
		seed = 32'h31c6;
		clk = 1'h0;
		reset = 1'h1;
		cfg_wr = 1'h0;
		cfg_rd = 1'h0;
		cfg_addr = 8'h00;
		cfg_be = 4'h0;
		cfg_wdata = 32'h0;
		nack_en = 1'h0;
		err_count = 0;
		samples_checked = 0;
		for (int i = 0; i < 256; i++) begin
			shadow[i] = 8'(i * 37 + 11);
		end
		do_reset();
		// Divisor sweep while the fast autoload runs
		for (int s = 0; s < 4; s++) begin
			reg_wr(8'h70, {24'h0, 2'h2, 2'(s), 4'h0}, 4'h1);
			repeat (3) measure();
			check("scl high", 32'(hi_len(s)), 32'(n));
		end
		reg_rd(8'h70);
		check("busy", 32'h1, {31'h0, v[8]});
		poll_clear(32'h100);
		check("autoload end", 32'h0000_00B8, v);
		check("load count", 32'h2, 32'(al_idx));
		$display("test autoload done");
		do_access(1'h1, 7'h7F, 16'hA55A, 1'h0);
		do_access(1'h0, 7'h7F, 16'h0000, 1'h0);
		do_access(1'h0, 7'h15, 16'h0000, 1'h1);
		do_access(1'h1, 7'h15, 16'h1234, 1'h1);
		repeat (3) begin
			rnd = 24'($random(seed));
			do_access(rnd[23], rnd[22:16], rnd[15:0], 1'h0);
		end
		keep = v;
		reg_wr(8'h74, 32'hFFFF_FFFF, 4'hF);
		reg_rd(8'h74);
		check("unmapped read", 32'h0, v);
		reg_rd(8'h70);
		check("unmapped write", keep, v);
		$display("test unmapped done");
		do_reset();
		reg_wr(8'h70, 32'h0000_00F0, 4'h1);
		poll_clear(32'h100);
		check("autoload off", 32'h0000_00F0, v);
		check("load count", 32'h1, 32'(al_idx));
		$display("test autoload disable done");
		conclude();
	end
endmodule : tb_top
